// *** design/ppoc_pkg.sv ***
// ppoc_pkg: constants and types for the downstream port power / overcurrent block
// assumes a 40 MHz core clock and an AXI4-Lite register bus with 32-bit data
package ppoc_pkg;
   localparam int NPORT = 3;
   // register byte offsets
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_MASK   = 8'h08;
   localparam logic [7:0] REG_PINS   = 8'h0C;
   // control register fields
   localparam int CTRL_EN_LSB     = 0;
   localparam int CTRL_SPLIT_BIT  = 3;
   localparam int CTRL_SS3_EN_BIT = 4;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [2:0]  MASK_RESET = 3'h0;
   // pins register fields
   localparam int PINS_OC_LSB   = 0;
   localparam int PINS_PWR_LSB  = 4;
   localparam int PINS_SS3_BIT  = 8;
   // axi responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [NPORT-1:0] pin_in;
      logic [NPORT-1:0] pin_out;
      logic [NPORT-1:0] pin_oe;
      logic [NPORT-1:0] pullup_en;
   } ppoc_pins_s;

   typedef enum logic [2:0] {
      WR_IDLE = 3'b001,
      WR_RESP = 3'b010,
      WR_HOLD = 3'b100
   } ppoc_wr_e;
endpackage

// *** design/ppoc_top.sv ***
// ppoc_top: power enable / overcurrent sense for downstream ports 1..3 and the
// separate superspeed power enable of port 3 in split mode
// assumes pins are synchronous to I_MCLK; the pad resolves pull-up and drive
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Operation
// - enabled port: pin is input with internal pull-up, pull-up powers port.
// - enabled port: low level on pin means overcurrent for that port.
// - disabled port: pin becomes output driven low, removing power.
// - port 3 pin governs both halves unless split, then only USB 2.0 half.
// - ports 1 and 2 pins always govern both halves together.
// - split mode: separate active-high output enables port 3 superspeed half.
module ppoc_top
   import ppoc_pkg::*;
(
   // clock and reset
   input  wire  logic              I_MCLK,
   input  wire  logic              I_RSTN,
   // hub control: host-side disable of each port
   input  wire  logic [NPORT-1:0]  I_HOST_PORT_ON,
   // port power pins
   input  wire  logic [NPORT-1:0]  I_PWR_PIN,
   output logic       [NPORT-1:0]  O_PWR_PIN,
   output logic       [NPORT-1:0]  O_PWR_PIN_OE,
   output logic       [NPORT-1:0]  O_PWR_PIN_PU,
   output logic                    O_PORT3_SS_PWR_EN,
   // port state to hub logic
   output logic       [NPORT-1:0]  O_PORT_ACTIVE,
   output logic       [NPORT-1:0]  O_PORT_SS_ACTIVE,
   output logic                    O_IRQ,
   // axi4-lite write address
   input  wire  logic [7:0]        S_AXI_AWADDR,
   input  wire  logic              S_AXI_AWVALID,
   output logic                    S_AXI_AWREADY,
   // axi4-lite write data
   input  wire  logic [31:0]       S_AXI_WDATA,
   input  wire  logic [3:0]        S_AXI_WSTRB,
   input  wire  logic              S_AXI_WVALID,
   output logic                    S_AXI_WREADY,
   // axi4-lite write response
   output logic [1:0]              S_AXI_BRESP,
   output logic                    S_AXI_BVALID,
   input  wire  logic              S_AXI_BREADY,
   // axi4-lite read address
   input  wire  logic [7:0]        S_AXI_ARADDR,
   input  wire  logic              S_AXI_ARVALID,
   output logic                    S_AXI_ARREADY,
   // axi4-lite read data
   output logic [31:0]             S_AXI_RDATA,
   output logic [1:0]              S_AXI_RRESP,
   output logic                    S_AXI_RVALID,
   input  wire  logic              S_AXI_RREADY
);

   function automatic logic mapped(input logic [7:0] a);
      return (a == REG_CTRL) || (a == REG_STATUS) || (a == REG_MASK) || (a == REG_PINS);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // register map, one word each, only byte 0 carries bits except pins bit 8:
   //   ctrl   : port enables, split mode, port 3 superspeed enable
   //   status : sticky overcurrent events, write one to clear
   //   mask   : interrupt enables, same layout as status
   //   pins   : live overcurrent, port power, superspeed enable out

   logic [NPORT-1:0]  cfg_en_q;
   logic              split_mode_q;
   logic              ss3_en_q;
   logic [NPORT-1:0]  oc_status_q;
   logic [NPORT-1:0]  oc_mask_q;
   logic [NPORT-1:0]  port_on;
   logic [NPORT-1:0]  oc_now;
   logic [NPORT-1:0]  pin_prev_q;
   ppoc_pins_s        pins;
   logic [NPORT-1:0]  oc_level;

   // awaddr / wdata capture
   logic              aw_have_q;
   logic              w_have_q;
   logic [7:0]        aw_addr_q;
   logic [31:0]       w_data_q;
   logic [3:0]        w_strb_q;
   ppoc_wr_e          wr_st_q;
   logic              wr_fire;
   logic              wr_ok;
   logic [NPORT-1:0]  st_clr;
   logic              wr_lo;
   logic [31:0]       rd_word;

   ////////////////////////////////////////////////////////////////////////////
   // port power pin control

   assign port_on = cfg_en_q & I_HOST_PORT_ON;

   always_comb begin
      pins.pin_in    = I_PWR_PIN;
      pins.pullup_en = port_on;
      pins.pin_oe    = ~port_on;
      pins.pin_out   = '0;
   end

   assign O_PWR_PIN    = pins.pin_out;
   assign O_PWR_PIN_OE = pins.pin_oe;
   assign O_PWR_PIN_PU = pins.pullup_en;

   // sampled only while the port is powered; a disabled pin is our own low drive
   assign oc_level = port_on & ~pins.pin_in;

   // edge detect: a monitor that holds its flag low raises one event, not a stream
   assign oc_now = oc_level & ~pin_prev_q;

   always_ff @(posedge I_MCLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         pin_prev_q <= '0;
      end else begin
         pin_prev_q <= oc_level;
      end
   end

   // ports 1 and 2 gate both halves; port 3 superspeed half leaves when split
   always_ff @(posedge I_MCLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         O_PORT_ACTIVE <= '0;
      end else begin
         O_PORT_ACTIVE <= port_on;
      end
   end

   always_ff @(posedge I_MCLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         O_PORT_SS_ACTIVE <= '0;
      end else begin
         O_PORT_SS_ACTIVE[1:0] <= port_on[1:0];
         O_PORT_SS_ACTIVE[2]   <= split_mode_q ? ss3_en_q : port_on[2];
      end
   end

   // the separate enable stays low outside split mode, where the pin owns both halves
   always_ff @(posedge I_MCLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         O_PORT3_SS_PWR_EN <= 1'b0;
      end else begin
         O_PORT3_SS_PWR_EN <= split_mode_q & ss3_en_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // overcurrent status and interrupt
   // set wins: an event in the cycle of a write-one clear is kept

   always_ff @(posedge I_MCLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         oc_status_q <= '0;
      end else begin
         oc_status_q <= (oc_status_q & ~st_clr) | oc_now;
      end
   end

   assign O_IRQ = |(oc_status_q & oc_mask_q);

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite write channel

   assign S_AXI_AWREADY = (wr_st_q == WR_IDLE) && !aw_have_q;
   assign S_AXI_WREADY  = (wr_st_q == WR_IDLE) && !w_have_q;
   assign wr_fire       = (wr_st_q == WR_IDLE) && aw_have_q && w_have_q;
   assign wr_ok         = mapped(aw_addr_q);
   // a write to a mapped offset without byte 0 enabled still answers okay but changes nothing
   assign wr_lo         = wr_fire && w_strb_q[0];
   assign st_clr = (wr_lo && aw_addr_q == REG_STATUS) ? w_data_q[NPORT-1:0] : '0;

   // address and data are taken in either order; the write fires once both are held
   always_ff @(posedge I_MCLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         aw_have_q <= 1'b0;
         aw_addr_q <= 8'h00;
      end else begin
         if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= S_AXI_AWADDR;
         end else if (wr_fire) begin
            aw_have_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge I_MCLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         w_have_q <= 1'b0;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
      end else begin
         if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_have_q <= 1'b1;
            w_data_q <= S_AXI_WDATA;
            w_strb_q <= S_AXI_WSTRB;
         end else if (wr_fire) begin
            w_have_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge I_MCLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         wr_st_q <= WR_IDLE;
      end else begin
         case (wr_st_q)
            WR_IDLE: begin
               if (wr_fire) begin
                  wr_st_q <= WR_RESP;
               end
            end
            WR_RESP: begin
               if (S_AXI_BREADY) begin
                  wr_st_q <= WR_IDLE;
               end
            end
            default: begin
               wr_st_q <= WR_IDLE;
            end
         endcase
      end
   end

   // response is held until the master takes it; an unmapped offset is refused
   always_ff @(posedge I_MCLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP  <= RESP_OKAY;
      end else if (wr_fire) begin
         S_AXI_BVALID <= 1'b1;
         S_AXI_BRESP  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
         S_AXI_BVALID <= 1'b0;
      end
   end

   // control register
   always_ff @(posedge I_MCLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         cfg_en_q     <= CTRL_RESET[CTRL_EN_LSB +: NPORT];
         split_mode_q <= CTRL_RESET[CTRL_SPLIT_BIT];
         ss3_en_q     <= CTRL_RESET[CTRL_SS3_EN_BIT];
      end else if (wr_lo && aw_addr_q == REG_CTRL) begin
         cfg_en_q     <= w_data_q[CTRL_EN_LSB +: NPORT];
         split_mode_q <= w_data_q[CTRL_SPLIT_BIT];
         ss3_en_q     <= w_data_q[CTRL_SS3_EN_BIT];
      end
   end

   // interrupt mask register
   always_ff @(posedge I_MCLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         oc_mask_q <= MASK_RESET;
      end else if (wr_lo && aw_addr_q == REG_MASK) begin
         oc_mask_q <= w_data_q[NPORT-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite read channel

   // one read at a time: a new address waits until the data has been taken
   assign S_AXI_ARREADY = !S_AXI_RVALID;

   // read word assembled combinationally, registered on the address handshake
   always_comb begin
      rd_word = 32'h0000_0000;
      case (S_AXI_ARADDR)
         REG_CTRL: begin
            rd_word[CTRL_EN_LSB +: NPORT] = cfg_en_q;
            rd_word[CTRL_SPLIT_BIT]       = split_mode_q;
            rd_word[CTRL_SS3_EN_BIT]      = ss3_en_q;
         end
         REG_STATUS: rd_word[NPORT-1:0] = oc_status_q;
         REG_MASK:   rd_word[NPORT-1:0] = oc_mask_q;
         REG_PINS: begin
            rd_word[PINS_OC_LSB +: NPORT]  = oc_level;
            rd_word[PINS_PWR_LSB +: NPORT] = port_on;
            rd_word[PINS_SS3_BIT]          = O_PORT3_SS_PWR_EN;
         end
         default: rd_word = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge I_MCLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA  <= 32'h0000_0000;
         S_AXI_RRESP  <= RESP_OKAY;
      end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
         S_AXI_RVALID <= 1'b1;
         S_AXI_RRESP  <= mapped(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
         S_AXI_RDATA  <= rd_word;
      end else if (S_AXI_RREADY) begin
         S_AXI_RVALID <= 1'b0;
      end
   end

endmodule

// *** bench/ppoc_switch_model.sv ***
// ppoc_switch_model: external port power switch with overcurrent flag
// assumes the pad resolves device drive against the internal pull-up
`timescale 1ns/1ps
module ppoc_switch_model
   import ppoc_pkg::*;
(
   // device side
   input  wire logic [NPORT-1:0] i_oe,
   input  wire logic [NPORT-1:0] i_pu,
   // bench side: switch flags overcurrent
   input  wire logic [NPORT-1:0] i_oc,
   // resolved pad level
   output logic      [NPORT-1:0] o_pin
);
   // drive low wins; flag pulls low; every pin stays wired
   assign o_pin = ~i_oe & i_pu & ~i_oc;
endmodule

// *** bench/ppoc_monitor.sv ***
// ppoc_monitor: concurrent checks on the ppoc_top ports
// assumes one clock domain with async active-low reset
`timescale 1ns/1ps
module ppoc_monitor
   import ppoc_pkg::*;
(
   input wire logic I_MCLK, I_RSTN, O_IRQ, O_PORT3_SS_PWR_EN,
   input wire logic [NPORT-1:0] I_HOST_PORT_ON, I_PWR_PIN, O_PWR_PIN_OE,
   input wire logic [NPORT-1:0] O_PWR_PIN_PU, O_PORT_ACTIVE, O_PORT_SS_ACTIVE,
   input wire logic S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY,
   input wire logic S_AXI_BVALID, S_AXI_ARVALID, S_AXI_ARREADY,
   input wire logic [7:0] S_AXI_ARADDR,
   input wire logic [1:0] S_AXI_RRESP,
   input wire logic [31:0] S_AXI_RDATA
);
   default clocking @(posedge I_MCLK); endclocking
   default disable iff (!I_RSTN);
   sequence wr_take;
      S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
   endsequence
   sequence wr_fire;
      !S_AXI_AWREADY ##1 S_AXI_BVALID;
   endsequence
   pin_mode_a: assert property (O_PWR_PIN_OE == ~O_PWR_PIN_PU)
      else $error("pin mode");
   host_off_a: assert property ((~I_HOST_PORT_ON & O_PWR_PIN_PU) == 3'h0)
      else $error("host off");
   port_active_a: assert property (O_PORT_ACTIVE == $past(O_PWR_PIN_PU))
      else $error("active");
   both_halves_a: assert property (O_PORT_SS_ACTIVE[1:0] == O_PORT_ACTIVE[1:0])
      else $error("halves");
   ss3_enable_a: assert property (O_PORT3_SS_PWR_EN |-> O_PORT_SS_ACTIVE[2])
      else $error("ss3");
   irq_cause_a: assert property ($rose(O_IRQ) |->
      $past(|(O_PWR_PIN_PU & ~I_PWR_PIN)) || $past(S_AXI_WVALID, 2)) else $error("irq");
   wr_resp_a: assert property (wr_take |=> wr_fire)
      else $error("wr resp");
   unmapped_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR > REG_PINS
      |=> S_AXI_RRESP == RESP_SLVERR && S_AXI_RDATA == 32'h0) else $error("unmapped");
endmodule
bind ppoc_top ppoc_monitor ppoc_monitor_inst (.*);

// *** bench/ppoc_top_tb.sv ***
// ppoc_top_tb: register-driven checks of port power and overcurrent
// assumes ppoc_top, ppoc_switch_model and ppoc_monitor compiled first
`timescale 1ns/1ps
module ppoc_top_tb import ppoc_pkg::*;;
   logic I_MCLK = 1'b0, I_RSTN = 1'b0, O_PORT3_SS_PWR_EN, O_IRQ;
   logic [NPORT-1:0] I_HOST_PORT_ON = 3'h7, oc = 3'h0, I_PWR_PIN, O_PWR_PIN;
   logic [NPORT-1:0] O_PWR_PIN_OE, O_PWR_PIN_PU, O_PORT_ACTIVE, O_PORT_SS_ACTIVE;
   logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
   logic S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0, S_AXI_AWREADY, S_AXI_WREADY;
   logic S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
   logic [7:0] S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00;
   logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA;
   logic [3:0] S_AXI_WSTRB = 4'hF;
   logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
   logic [6:0] st;
   int failures = 0, compares = 0, cyc = 0;
   assign st = {O_PORT3_SS_PWR_EN, O_PORT_SS_ACTIVE, O_PORT_ACTIVE};
   ppoc_top ppoc_top_inst (.*);
   ppoc_switch_model ppoc_switch_model_inst (.i_oe(O_PWR_PIN_OE), .i_pu(O_PWR_PIN_PU),
      .i_oc(oc), .o_pin(I_PWR_PIN));
   initial forever #12.5 I_MCLK = ~I_MCLK;
   always @(posedge I_MCLK) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         failures++;
         wrap_up();
      end
   end
   task automatic wrap_up;
      if (failures == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic tk;
      @(posedge I_MCLK);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw, w;
      @(posedge I_MCLK);
      aw = 1'b1;
      w = 1'b1;
      S_AXI_AWADDR <= a;
      S_AXI_WDATA <= d;
      S_AXI_AWVALID <= 1'b1;
      S_AXI_WVALID <= 1'b1;
      S_AXI_BREADY <= 1'b1;
      while (aw | w) begin
         @(posedge I_MCLK);
         aw &= ~S_AXI_AWREADY;
         w &= ~S_AXI_WREADY;
         S_AXI_AWVALID <= aw;
         S_AXI_WVALID <= w;
      end
      while (!S_AXI_BVALID) @(posedge I_MCLK);
      S_AXI_BREADY <= 1'b0;
      chk(32'(S_AXI_BRESP), 32'(er));
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge I_MCLK);
      S_AXI_ARADDR <= a;
      S_AXI_ARVALID <= 1'b1;
      S_AXI_RREADY <= 1'b1;
      do @(posedge I_MCLK); while (!S_AXI_ARREADY);
      S_AXI_ARVALID <= 1'b0;
      while (!S_AXI_RVALID) @(posedge I_MCLK);
      S_AXI_RREADY <= 1'b0;
      chk(S_AXI_RDATA, e);
      chk(32'(S_AXI_RRESP), 32'(er));
   endtask
   initial begin
      repeat (5) @(posedge I_MCLK);
      I_RSTN <= 1'b1;
      tk();
      chk(32'(O_PWR_PIN_OE), 32'h7);
      chk(32'(O_PWR_PIN), 32'h0);
      rd(REG_CTRL, CTRL_RESET, RESP_OKAY);
      rd(REG_MASK, 32'(MASK_RESET), RESP_OKAY);
      wr(REG_CTRL, 32'h7, RESP_OKAY);
      chk(32'(O_PWR_PIN_PU), 32'h7);
      tk();
      tk();
      chk(32'(st), 32'h3F);
      wr(REG_MASK, 32'h7, RESP_OKAY);
      oc <= 3'h2;
      tk();
      tk();
      chk(32'(O_IRQ), 32'h1);
      rd(REG_PINS, 32'h72, RESP_OKAY);
      oc <= 3'h0;
      rd(REG_STATUS, 32'h2, RESP_OKAY);
      wr(REG_STATUS, 32'h2, RESP_OKAY);
      rd(REG_STATUS, 32'h0, RESP_OKAY);
      I_HOST_PORT_ON <= 3'h6;
      oc <= 3'h1;
      tk();
      chk(32'(O_PWR_PIN_OE), 32'h1);
      rd(REG_STATUS, 32'h0, RESP_OKAY);
      I_HOST_PORT_ON <= 3'h7;
      oc <= 3'h0;
      wr(REG_CTRL, 32'h1F, RESP_OKAY);
      tk();
      tk();
      chk(32'(st), 32'h7F);
      wr(REG_CTRL, 32'h0F, RESP_OKAY);
      tk();
      tk();
      chk(32'(st), 32'h1F);
      wr(REG_CTRL, 32'h13, RESP_OKAY);
      tk();
      tk();
      chk(32'(st), 32'h1B);
      chk(32'(O_PWR_PIN_OE), 32'h4);
      rd(REG_PINS, 32'h30, RESP_OKAY);
      wr(REG_CTRL, 32'h1B, RESP_OKAY);
      tk();
      tk();
      chk(32'(st), 32'h7B);
      chk(32'(O_PWR_PIN_OE), 32'h4);
      chk(32'(O_PWR_PIN), 32'h0);
      wr(REG_MASK, 32'h5, RESP_OKAY);
      oc <= 3'h2;
      tk();
      tk();
      chk(32'(O_IRQ), 32'h0);
      rd(REG_STATUS, 32'h2, RESP_OKAY);
      wr(REG_STATUS, 32'h2, RESP_OKAY);
      rd(REG_STATUS, 32'h0, RESP_OKAY);
      oc <= 3'h0;
      wr(8'h10, 32'h7, RESP_SLVERR);
      rd(8'h10, 32'h0, RESP_SLVERR);
      wrap_up();
   end
endmodule
